// ==== hw/ccs_status_core.sv ====
// Status core behind the common commands: event, status byte, masks, replies
//
// Behaviour
// RULE1 - Reset command restores power-on state but keeps both enable masks.
// RULE2 - Reset command leaves output queue and power-on clear flag untouched.
// RULE3 - Self-test query tests data memory, answers 0 pass, 1 fail.
// RULE4 - Clear-status zeroes event register and summary, keeps every enable mask.
// RULE5 - After operation-complete command, set event bit 0 once command finishes.
// RULE6 - Operation-complete query answers ASCII 1 after last command finished.
// RULE7 - After wait command, hold off further commands until nothing pending.
// RULE8 - Event query returns event register as decimal sum, up to 255.
// RULE9 - Status bit 5 is OR of event bits selected by event mask.
// RULE10 - Event enable query returns event mask as decimal 0 to 255.
// RULE11 - Status byte query returns status byte as decimal 0 to 255.
// RULE12 - Raise service request when a set status bit is enabled.
// RULE13 - Service request enable query returns mask as decimal 0 to 255.
// RULE14 - Power-on clear flag 1 clears both enable masks at power up.
// RULE15 - Power-on clear flag 0 loads both masks from non-volatile copies.
// RULE16 - Power-on clear query answers the flag value, 0 or 1.
// RULE17 - Event bits: 0 done, 2 query, 3 device, 4 execution, 5 command, 7 power.
// RULE18 - Status bits: pass, fail, abort, process, message, summary, request, prompt.
// RULE19 - Request bit 6 from other status bits masked, bit 6 excluded.
`timescale 1ns/1ps
module ccs_status_core
   import ccs_pkg::*;
#(
   parameter int MEM_DEPTH = 16
)(
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // Command port
   input wire logic i_req_valid,
   input wire ccs_req_s i_req,
   output logic o_req_ready,
   // Response character stream
   output logic o_rsp_valid,
   output ccs_rsp_s o_rsp,
   input wire logic i_rsp_ready,
   // Application side
   input wire ccs_app_s i_app,
   input wire logic i_op_pending,
   input wire logic i_mem_fault,
   // Non-volatile copies
   input wire logic [7:0] i_nv_ese,
   input wire logic [7:0] i_nv_sre,
   input wire logic i_nv_psc,
   output logic o_nv_psc_we,
   output logic o_nv_psc,
   // Status outputs
   output logic o_srq,
   output logic o_rst_cfg,
   output logic [7:0] o_standard_event,
   output logic [7:0] o_standard_event_enable,
   output logic [7:0] o_status_summary_byte,
   output logic [7:0] o_service_request_enable,
   output logic o_psc
);
   initial begin
      if (MEM_DEPTH < 2) begin
         $error("MEM_DEPTH too small");
      end
   end

   typedef enum logic [2:0] {
      CCS_ST_POWERUP = 3'b000,
      CCS_ST_IDLE = 3'b001,
      CCS_ST_WAIT = 3'b010,
      CCS_ST_TEST = 3'b011,
      CCS_ST_OPCQ = 3'b100,
      CCS_ST_SEND = 3'b101
   } ccs_st_e;

   ccs_st_e state;
   logic [7:0] standard_event;
   logic [7:0] standard_event_enable;
   logic [7:0] service_request_enable;
   logic psc;
   logic opc_armed;
   logic [7:0] rsp_value;
   logic rsp_single;
   logic [1:0] dig_idx;
   logic [7:0] status_summary_byte;
   logic esb;
   logic rqs;
   logic take;
   logic mt_start;
   logic mt_busy;
   logic mt_done;
   logic mt_fail;
   logic [7:0] d_hund;
   logic [7:0] d_tens;
   logic [7:0] d_ones;
   logic [1:0] d_ndig;
   logic [1:0] next_dig_idx;
   logic [1:0] dig_start;
   logic [1:0] dig_cur;

   ccs_mem_test #(
      .DEPTH(MEM_DEPTH)
   ) u_mem_test (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_start(mt_start),
      .i_fault(i_mem_fault),
      .o_busy(mt_busy),
      .o_done(mt_done),
      .o_fail(mt_fail)
   );

   ccs_dec_fmt u_dec_fmt (
      .i_value(rsp_value),
      .o_hund(d_hund),
      .o_tens(d_tens),
      .o_ones(d_ones),
      .o_ndig(d_ndig)
   );

   // Status byte composition
   assign esb = |(standard_event & standard_event_enable); // RULE9
   always_comb begin
      status_summary_byte = CCS_BYTE_ZERO; // RULE18
      status_summary_byte[CCS_SB_PASS] = i_app.all_pass;
      status_summary_byte[CCS_SB_FAIL] = i_app.fail;
      status_summary_byte[CCS_SB_ABORT] = i_app.abort;
      status_summary_byte[CCS_SB_PROC] = i_app.process;
      status_summary_byte[CCS_SB_MAV] = i_app.msg_avail;
      status_summary_byte[CCS_SB_ESB] = esb;
      status_summary_byte[CCS_SB_PROMPT] = i_app.prompt;
      // Bit 6 is still zero in the byte when the mask is applied, so the request cannot latch itself
      rqs = |(status_summary_byte & service_request_enable); // RULE19 RULE12
      status_summary_byte[CCS_SB_RQS] = rqs; // RULE19
   end

   // Commands accepted only when idle and nothing blocks
   assign o_req_ready = (state == CCS_ST_IDLE);
   assign take = i_req_valid & o_req_ready;
   assign mt_start = take && (i_req.code == CCS_CMD_TST);

   // Command sequencing and response selection
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         state <= CCS_ST_POWERUP;
         rsp_value <= CCS_BYTE_ZERO;
         rsp_single <= 1'b0;
      end else begin
         unique case (state)
            CCS_ST_POWERUP: state <= CCS_ST_IDLE;
            CCS_ST_IDLE: begin
               if (take) begin
                  rsp_single <= 1'b0;
                  unique case (i_req.code)
                     CCS_CMD_WAI: state <= CCS_ST_WAIT; // RULE7
                     CCS_CMD_TST: state <= CCS_ST_TEST; // RULE3
                     CCS_CMD_OPCQ: state <= CCS_ST_OPCQ; // RULE6
                     CCS_CMD_ESRQ: begin
                        rsp_value <= standard_event; // RULE8
                        state <= CCS_ST_SEND;
                     end
                     CCS_CMD_ESEQ: begin
                        rsp_value <= standard_event_enable; // RULE10
                        state <= CCS_ST_SEND;
                     end
                     CCS_CMD_STBQ: begin
                        rsp_value <= status_summary_byte; // RULE11
                        state <= CCS_ST_SEND;
                     end
                     CCS_CMD_SREQ: begin
                        rsp_value <= service_request_enable; // RULE13
                        state <= CCS_ST_SEND;
                     end
                     CCS_CMD_PSCQ: begin
                        rsp_value <= {7'h00, psc}; // RULE16
                        state <= CCS_ST_SEND;
                     end
                     default: state <= CCS_ST_IDLE;
                  endcase
               end
            end
            CCS_ST_WAIT: begin
               if (!i_op_pending) begin
                  state <= CCS_ST_IDLE; // RULE7
               end
            end
            CCS_ST_TEST: begin
               if (mt_done) begin
                  rsp_value <= {7'h00, mt_fail}; // RULE3
                  state <= CCS_ST_SEND;
               end
            end
            CCS_ST_OPCQ: begin
               if (!i_op_pending) begin
                  rsp_value <= {7'h00, 1'b1}; // RULE6
                  state <= CCS_ST_SEND;
               end
            end
            CCS_ST_SEND: begin
               if (i_rsp_ready && dig_cur == CCS_DIG_MAX) begin
                  state <= CCS_ST_IDLE;
               end
            end
            default: state <= CCS_ST_IDLE;
         endcase
      end
   end

   // Digit walk: skips leading zeros of the reply now held, ends at the ones digit
   // Start follows the held reply, which loads on the same edge that enters sending
   always_comb begin
      dig_start = CCS_DIG_MAX - d_ndig;
      dig_cur = (dig_idx < dig_start) ? dig_start : dig_idx;
      next_dig_idx = dig_idx;
      if (state != CCS_ST_SEND) begin
         next_dig_idx = '0;
      end else if (i_rsp_ready && dig_cur != CCS_DIG_MAX) begin
         next_dig_idx = dig_cur + 2'h1;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         dig_idx <= CCS_DIG_MAX;
      end else begin
         dig_idx <= next_dig_idx;
      end
   end

   always_comb begin
      o_rsp.last = (dig_cur == CCS_DIG_MAX);
      unique case (dig_cur)
         2'h0: o_rsp.chr = d_hund;
         2'h1: o_rsp.chr = d_tens;
         default: o_rsp.chr = d_ones;
      endcase
   end
   assign o_rsp_valid = (state == CCS_ST_SEND);

   // Operation-complete arming
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         opc_armed <= 1'b0;
      end else if (take && i_req.code == CCS_CMD_OPC) begin
         opc_armed <= 1'b1; // RULE5
      end else if (take && (i_req.code == CCS_CMD_CLS || i_req.code == CCS_CMD_RST)) begin
         opc_armed <= 1'b0;
      end else if (opc_armed && !i_op_pending && state == CCS_ST_IDLE) begin
         opc_armed <= 1'b0;
      end
   end

   // Standard event register: hardware sets win over clear-status
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         standard_event <= CCS_BYTE_ZERO;
      end else if (state == CCS_ST_POWERUP) begin
         standard_event <= CCS_BYTE_ZERO;
         standard_event[CCS_EV_PON] <= 1'b1; // RULE17
      end else begin
         if (take && i_req.code == CCS_CMD_CLS) begin
            standard_event <= CCS_BYTE_ZERO; // RULE4
         end
         if (opc_armed && !i_op_pending && state == CCS_ST_IDLE) begin
            standard_event[CCS_EV_OPC] <= 1'b1; // RULE5
         end
         if (i_app.query_err) begin
            standard_event[CCS_EV_QRY] <= 1'b1; // RULE17
         end
         if (i_app.device_err) begin
            standard_event[CCS_EV_DEV] <= 1'b1; // RULE17
         end
         if (i_app.exec_err) begin
            standard_event[CCS_EV_EXE] <= 1'b1; // RULE17
         end
         if (i_app.cmd_err || (take && i_req.code == CCS_CMD_OTHER)) begin
            standard_event[CCS_EV_CMD] <= 1'b1; // RULE17
         end
      end
   end

   // Power-on clear flag is captured once after reset, reset command ignores it
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         psc <= 1'b0;
      end else if (state == CCS_ST_POWERUP) begin
         psc <= i_nv_psc;
      end else if (take && i_req.code == CCS_CMD_PSC) begin
         psc <= i_req.arg != CCS_BYTE_ZERO;
      end
   end
   assign o_nv_psc_we = take && (i_req.code == CCS_CMD_PSC);
   assign o_nv_psc = i_req.arg != CCS_BYTE_ZERO;

   // Enable masks: power up per flag; reset command and clear-status keep them
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         standard_event_enable <= CCS_BYTE_ZERO;
         service_request_enable <= CCS_BYTE_ZERO;
      end else if (state == CCS_ST_POWERUP) begin
         if (i_nv_psc) begin
            standard_event_enable <= CCS_BYTE_ZERO; // RULE14
            service_request_enable <= CCS_BYTE_ZERO; // RULE14
         end else begin
            standard_event_enable <= i_nv_ese; // RULE15
            service_request_enable <= i_nv_sre; // RULE15
         end
      end else if (take && i_req.code == CCS_CMD_ESE) begin
         standard_event_enable <= i_req.arg & CCS_EV_USED;
      end else if (take && i_req.code == CCS_CMD_SRE) begin
         service_request_enable <= i_req.arg;
      end
   end

   // Reset command pulse to the rest of the instrument, queue untouched
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_rst_cfg <= 1'b0;
      end else begin
         o_rst_cfg <= take && (i_req.code == CCS_CMD_RST); // RULE1 RULE2
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_srq <= 1'b0;
         o_status_summary_byte <= CCS_BYTE_ZERO;
      end else begin
         o_srq <= rqs; // RULE12
         o_status_summary_byte <= status_summary_byte;
      end
   end

   assign o_standard_event = standard_event;
   assign o_standard_event_enable = standard_event_enable;
   assign o_service_request_enable = service_request_enable;
   assign o_psc = psc;

   logic unused_busy;
   assign unused_busy = mt_busy;
endmodule

// ==== include/ccs_pkg.sv ====
// Package for the common command status model: codes, bit positions, structs
package ccs_pkg;

   // Command codes presented on the command port
   typedef enum logic [3:0] {
      CCS_CMD_RST = 4'h0,
      CCS_CMD_TST = 4'h1,
      CCS_CMD_CLS = 4'h2,
      CCS_CMD_OPC = 4'h3,
      CCS_CMD_OPCQ = 4'h4,
      CCS_CMD_WAI = 4'h5,
      CCS_CMD_ESRQ = 4'h6,
      CCS_CMD_ESE = 4'h7,
      CCS_CMD_ESEQ = 4'h8,
      CCS_CMD_STBQ = 4'h9,
      CCS_CMD_SRE = 4'ha,
      CCS_CMD_SREQ = 4'hb,
      CCS_CMD_PSC = 4'hc,
      CCS_CMD_PSCQ = 4'hd,
      CCS_CMD_OTHER = 4'he
   } ccs_cmd_e;

   // Standard event bit positions
   localparam int CCS_EV_OPC = 0;
   localparam int CCS_EV_QRY = 2;
   localparam int CCS_EV_DEV = 3;
   localparam int CCS_EV_EXE = 4;
   localparam int CCS_EV_CMD = 5;
   localparam int CCS_EV_PON = 7;
   localparam logic [7:0] CCS_EV_USED = 8'hbd;

   // Status byte bit positions
   localparam int CCS_SB_PASS = 0;
   localparam int CCS_SB_FAIL = 1;
   localparam int CCS_SB_ABORT = 2;
   localparam int CCS_SB_PROC = 3;
   localparam int CCS_SB_MAV = 4;
   localparam int CCS_SB_ESB = 5;
   localparam int CCS_SB_RQS = 6;
   localparam int CCS_SB_PROMPT = 7;

   localparam logic [7:0] CCS_BYTE_ZERO = 8'h00;
   localparam logic [7:0] CCS_ASCII_ZERO = 8'h30;
   localparam logic [7:0] CCS_ASCII_ONE = 8'h31;
   localparam logic [7:0] CCS_ASCII_NINE = 8'h39;
   localparam logic [7:0] CCS_DEC_TEN = 8'h0a;
   localparam logic [7:0] CCS_DEC_HUNDRED = 8'h64;
   localparam logic [7:0] CCS_TST_PATTERN = 8'ha5;
   localparam logic [1:0] CCS_DIG_MAX = 2'h2;

   // One command from the parser
   typedef struct packed {
      ccs_cmd_e code;
      logic [7:0] arg;
   } ccs_req_s;

   // One response character
   typedef struct packed {
      logic [7:0] chr;
      logic last;
   } ccs_rsp_s;

   // Application status inputs feeding the status byte and event register
   typedef struct packed {
      logic all_pass;
      logic fail;
      logic abort;
      logic process;
      logic prompt;
      logic msg_avail;
      logic query_err;
      logic device_err;
      logic exec_err;
      logic cmd_err;
   } ccs_app_s;

endpackage

// ==== hw/ccs_dec_fmt.sv ====
// Byte to up-to-three ASCII decimal digits, most significant first
`timescale 1ns/1ps
module ccs_dec_fmt
   import ccs_pkg::*;
(
   input wire logic [7:0] i_value,
   output logic [7:0] o_hund,
   output logic [7:0] o_tens,
   output logic [7:0] o_ones,
   output logic [1:0] o_ndig
);
   logic [7:0] h;
   logic [7:0] rem;
   logic [7:0] t;
   always_comb begin
      h = i_value / CCS_DEC_HUNDRED;
      rem = i_value - h * CCS_DEC_HUNDRED;
      t = rem / CCS_DEC_TEN;
      o_hund = CCS_ASCII_ZERO + h;
      o_tens = CCS_ASCII_ZERO + t;
      o_ones = CCS_ASCII_ZERO + (rem - t * CCS_DEC_TEN);
      if (h != CCS_BYTE_ZERO) begin
         o_ndig = 2'h2;
      end else if (t != CCS_BYTE_ZERO) begin
         o_ndig = 2'h1;
      end else begin
         o_ndig = 2'h0;
      end
   end
endmodule

// ==== hw/ccs_mem_test.sv ====
// Write-read walk over a small data memory, reports pass or fail
`timescale 1ns/1ps
module ccs_mem_test
   import ccs_pkg::*;
#(
   parameter int DEPTH = 16
)(
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_start,
   input wire logic i_fault,
   output logic o_busy,
   output logic o_done,
   output logic o_fail
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
         $error("DEPTH must be a power of two, at least 2");
      end
   end

   typedef enum logic [1:0] {
      CCS_MT_IDLE = 2'b00,
      CCS_MT_WRITE = 2'b01,
      CCS_MT_READ = 2'b10
   } ccs_mt_e;

   ccs_mt_e state;
   logic [AW-1:0] addr;
   logic [7:0] mem [DEPTH];
   logic [7:0] pat;
   logic err;

   assign pat = CCS_TST_PATTERN ^ {{(8-AW){1'b0}}, addr};

   always_ff @(posedge i_ref_clk) begin
      if (state == CCS_MT_WRITE) begin
         // Injected fault corrupts one bit so failing memory can be modelled
         mem[addr] <= pat ^ {7'h00, i_fault};
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         state <= CCS_MT_IDLE;
         addr <= '0;
         err <= 1'b0;
         o_done <= 1'b0;
         o_fail <= 1'b0;
      end else begin
         o_done <= 1'b0;
         unique case (state)
            CCS_MT_IDLE: begin
               if (i_start) begin
                  state <= CCS_MT_WRITE;
                  addr <= '0;
                  err <= 1'b0;
               end
            end
            CCS_MT_WRITE: begin
               addr <= addr + 1'b1;
               if (addr == AW'(DEPTH - 1)) begin
                  state <= CCS_MT_READ;
               end
            end
            CCS_MT_READ: begin
               addr <= addr + 1'b1;
               if (addr == AW'(DEPTH - 1)) begin
                  state <= CCS_MT_IDLE;
                  o_done <= 1'b1;
                  o_fail <= err | (mem[addr] != pat);
               end else begin
                  err <= err | (mem[addr] != pat);
               end
            end
            default: state <= CCS_MT_IDLE;
         endcase
      end
   end

   assign o_busy = (state != CCS_MT_IDLE);
endmodule

// ==== test/ccs_status_asserts.sv ====
// Port-level checks for the common command status core
`timescale 1ns/1ps
module ccs_status_asserts
   import ccs_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_req_valid,
   input wire ccs_req_s i_req,
   input wire logic o_req_ready,
   input wire logic o_rsp_valid,
   input wire logic i_op_pending,
   input wire logic o_rst_cfg,
   input wire logic [7:0] o_standard_event,
   input wire logic [7:0] o_standard_event_enable,
   input wire logic [7:0] o_status_summary_byte,
   input wire logic [7:0] o_service_request_enable,
   input wire logic o_srq
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);

   // Command accepted this cycle
   sequence s_take(ccs_cmd_e c);
      i_req_valid && o_req_ready && i_req.code == c;
   endsequence

   // Work still outstanding for three cycles after a take
   sequence s_held(ccs_cmd_e c);
      s_take(c) ##1 i_op_pending [*3];
   endsequence

   esb_sum_a:
   assert property (o_status_summary_byte[CCS_SB_ESB] ==
      |($past(o_standard_event) & $past(o_standard_event_enable))) else $error("summary bit wrong");
   rqs_mask_a:
   assert property (o_status_summary_byte[CCS_SB_RQS] ==
      |(o_status_summary_byte & 8'hbf & $past(o_service_request_enable)))
      else $error("request bit wrong");
   srq_out_a:
   assert property (o_srq == o_status_summary_byte[CCS_SB_RQS]) else $error("srq mismatch");
   pon_set_a:
   assert property ($fell(i_rst) |-> ##[1:3] o_standard_event[CCS_EV_PON])
      else $error("power-on bit missing");
   ese_write_a:
   assert property (s_take(CCS_CMD_ESE) |=> o_standard_event_enable ==
      ($past(i_req.arg) & CCS_EV_USED)) else $error("event mask write wrong");
   opc_done_a:
   assert property (s_take(CCS_CMD_OPC) ##1 !i_op_pending [*2] |-> ##[0:3]
      o_standard_event[CCS_EV_OPC]) else $error("complete bit not set");
   wai_hold_a:
   assert property (s_held(CCS_CMD_WAI) |-> !o_req_ready) else $error("wait did not hold");
   opcq_hold_a:
   assert property (s_held(CCS_CMD_OPCQ) |-> !o_rsp_valid) else $error("early complete reply");
   cls_clear_a:
   assert property (s_take(CCS_CMD_CLS) |=> o_standard_event == CCS_BYTE_ZERO &&
      $stable(o_standard_event_enable)) else $error("clear status wrong");
   rst_keep_a:
   assert property (s_take(CCS_CMD_RST) |-> ##[1:2] o_rst_cfg ##0
      $stable(o_service_request_enable)) else $error("reset command wrong");
endmodule

bind ccs_status_core ccs_status_asserts u_chk (.i_ref_clk, .i_rst, .i_req_valid, .i_req,
   .o_req_ready, .o_rsp_valid, .i_op_pending, .o_rst_cfg, .o_standard_event,
   .o_standard_event_enable, .o_status_summary_byte, .o_service_request_enable, .o_srq);

// ==== test/ccs_host_model.sv ====
// Host model issuing commands and collecting decimal replies
`timescale 1ns/1ps
module ccs_host_model
   import ccs_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_req_ready,
   output logic o_req_valid,
   output ccs_req_s o_req,
   input wire logic i_rsp_valid,
   input wire ccs_rsp_s i_rsp,
   output logic o_rsp_ready
);
   logic slow = 1'b0;
   initial begin
      o_req_valid = 1'b0;
      o_req = '0;
      o_rsp_ready = 1'b1;
   end
   // Slow mode takes a digit only every other cycle
   always @(posedge i_ref_clk) begin
      #1 o_rsp_ready <= slow ? ~o_rsp_ready : 1'b1;
   end

   task automatic ran_out();
      $display("BAD %0t wait got %h exp %h", $time, 1'b0, 1'b1);
      common_command_status_model_tb.n_fail++;
      common_command_status_model_tb.finish_test();
   endtask

   task automatic send(input ccs_cmd_e c, input logic [7:0] a);
      int n;
      n = 0;
      @(posedge i_ref_clk);
      #1;
      o_req_valid = 1'b1;
      o_req = '{code: c, arg: a};
      @(negedge i_ref_clk);
      while (i_req_ready !== 1'b1) begin
         n++;
         if (n > 400) ran_out();
         @(negedge i_ref_clk);
      end
      @(posedge i_ref_clk);
      #1;
      o_req_valid = 1'b0;
      // Released lines do not keep the old command
      o_req = ~o_req;
   endtask

   task automatic query(input ccs_cmd_e c, input logic [7:0] a, output logic [31:0] v);
      int n;
      bit done;
      n = 0;
      done = 1'b0;
      v = '0;
      send(c, a);
      while (!done) begin
         @(negedge i_ref_clk);
         if (i_rsp_valid === 1'b1 && o_rsp_ready) begin
            v = v * 10 + 32'(i_rsp.chr - CCS_ASCII_ZERO);
            done = i_rsp.last;
         end
         n++;
         if (n > 400) ran_out();
      end
      @(posedge i_ref_clk);
      #1;
   endtask
endmodule

// ==== test/common_command_status_model_tb.sv ====
// Self-checking bench for the common command status core
`timescale 1ns/1ps
module common_command_status_model_tb;
   import ccs_pkg::*;
   localparam ccs_app_s APP_IDLE = '{all_pass: 1'b1, default: 1'b0};
   localparam ccs_app_s APP_ERR = '{all_pass: 1'b1, query_err: 1'b1, device_err: 1'b1,
      exec_err: 1'b1, default: 1'b0};
   logic i_ref_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_req_valid, o_req_ready, o_rsp_valid, i_rsp_ready, o_nv_psc_we, o_nv_psc;
   logic o_srq, o_rst_cfg, o_psc;
   logic [7:0] o_standard_event, o_standard_event_enable;
   logic [7:0] o_status_summary_byte, o_service_request_enable;
   ccs_req_s i_req;
   ccs_rsp_s o_rsp;
   ccs_app_s i_app = APP_IDLE;
   logic i_op_pending = 1'b0;
   logic i_mem_fault = 1'b0;
   logic [7:0] i_nv_ese = 8'h24;
   logic [7:0] i_nv_sre = 8'h20;
   logic i_nv_psc = 1'b0;
   int n_fail = 0;
   int checks_done = 0;
   int n_nv_we = 0;

   always #2 i_ref_clk = ~i_ref_clk;

   // Stores of a set power-on clear flag to the non-volatile copy
   always @(posedge i_ref_clk) begin
      if (o_nv_psc_we === 1'b1 && o_nv_psc === 1'b1) begin
         n_nv_we++;
      end
   end

   ccs_status_core #(.MEM_DEPTH(4)) DUT (.i_ref_clk, .i_rst, .i_req_valid, .i_req,
      .o_req_ready, .o_rsp_valid, .o_rsp, .i_rsp_ready, .i_app, .i_op_pending, .i_mem_fault,
      .i_nv_ese, .i_nv_sre, .i_nv_psc, .o_nv_psc_we, .o_nv_psc, .o_srq, .o_rst_cfg,
      .o_standard_event, .o_standard_event_enable, .o_status_summary_byte,
      .o_service_request_enable, .o_psc);

   ccs_host_model host (.i_ref_clk, .i_req_ready(o_req_ready), .o_req_valid(i_req_valid),
      .o_req(i_req), .i_rsp_valid(o_rsp_valid), .i_rsp(o_rsp), .o_rsp_ready(i_rsp_ready));

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic q(input ccs_cmd_e c, input logic [31:0] exp);
      logic [31:0] v;
      host.query(c, 8'h00, v);
      chk(v, exp);
   endtask

   task automatic do_reset();
      i_rst = 1'b1;
      repeat (10) @(posedge i_ref_clk);
      #1 i_rst = 1'b0;
   endtask

   // Query while work is pending; pending clears after ten cycles
   task automatic held(input ccs_cmd_e c, input logic [31:0] exp);
      logic [31:0] v;
      time t0;
      time tq;
      fork
         begin
            host.query(c, 8'h00, v);
            tq = $time;
         end
         begin
            repeat (10) @(posedge i_ref_clk);
            t0 = $time;
            #1 i_op_pending = 1'b0;
         end
      join
      chk(v, exp);
      chk(32'(tq > t0), 32'h1);
   endtask

   initial begin
      do_reset();
      q(CCS_CMD_ESEQ, 36);
      q(CCS_CMD_SREQ, 32);
      q(CCS_CMD_PSCQ, 0);
      q(CCS_CMD_ESRQ, 128);
      q(CCS_CMD_STBQ, 1);
      host.send(CCS_CMD_ESE, 8'hff);
      q(CCS_CMD_ESEQ, 189);
      host.send(CCS_CMD_SRE, 8'h20);
      q(CCS_CMD_STBQ, 97);
      chk(32'(o_srq), 32'h1);
      q(CCS_CMD_SREQ, 32);
      i_app = APP_ERR;
      @(posedge i_ref_clk);
      #1 i_app = APP_IDLE;
      host.send(CCS_CMD_OTHER, 8'h00);
      host.slow = 1'b1;
      q(CCS_CMD_ESRQ, 188);
      host.slow = 1'b0;
      host.send(CCS_CMD_CLS, 8'h00);
      q(CCS_CMD_ESRQ, 0);
      q(CCS_CMD_ESEQ, 189);
      q(CCS_CMD_STBQ, 1);
      chk(32'(o_srq), 32'h0);
      i_op_pending = 1'b1;
      host.send(CCS_CMD_OPC, 8'h00);
      repeat (5) @(posedge i_ref_clk);
      q(CCS_CMD_ESRQ, 0);
      i_op_pending = 1'b0;
      repeat (3) @(posedge i_ref_clk);
      q(CCS_CMD_ESRQ, 1);
      host.send(CCS_CMD_CLS, 8'h00);
      host.send(CCS_CMD_OPC, 8'h00);
      q(CCS_CMD_ESRQ, 1);
      host.send(CCS_CMD_CLS, 8'h00);
      i_op_pending = 1'b1;
      host.send(CCS_CMD_WAI, 8'h00);
      held(CCS_CMD_ESRQ, 0);
      i_op_pending = 1'b1;
      held(CCS_CMD_OPCQ, 1);
      q(CCS_CMD_TST, 0);
      i_mem_fault = 1'b1;
      q(CCS_CMD_TST, 1);
      i_mem_fault = 1'b0;
      host.send(CCS_CMD_PSC, 8'h01);
      chk(32'(n_nv_we), 32'h1);
      q(CCS_CMD_PSCQ, 1);
      chk(32'(o_psc), 32'h1);
      host.send(CCS_CMD_RST, 8'h00);
      q(CCS_CMD_PSCQ, 1);
      q(CCS_CMD_ESEQ, 189);
      q(CCS_CMD_SREQ, 32);
      i_nv_psc = 1'b1;
      do_reset();
      q(CCS_CMD_ESEQ, 0);
      q(CCS_CMD_SREQ, 0);
      finish_test();
   end
endmodule
